// [pwm16_pkg.sv]
// Package with constants and types for the dual-slope PWM timer
package pwm16_pkg;
  // ----------------------------------------
  // Register map (APB byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_CMP_A = 8'h08;
  localparam logic [7:0] ADDR_CMP_B = 8'h0C;
  localparam logic [7:0] ADDR_CAPT = 8'h10;
  localparam logic [7:0] ADDR_FLAGS = 8'h14;
  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PRE_LSB = 4;
  localparam int CTRL_COMA_LSB = 8;
  localparam int CTRL_COMB_LSB = 10;
  localparam int CTRL_DIRA_BIT = 12;
  localparam int CTRL_DIRB_BIT = 13;
  // Flag bit positions
  localparam int FLG_OVF = 0;
  localparam int FLG_CMPA = 1;
  localparam int FLG_CMPB = 2;
  localparam int FLG_CAPT = 3;
  // ----------------------------------------
  // Mode codes and TOP values
  // ----------------------------------------
  localparam logic [3:0] MODE_PC8 = 4'h1;
  localparam logic [3:0] MODE_PC9 = 4'h2;
  localparam logic [3:0] MODE_PC10 = 4'h3;
  localparam logic [3:0] MODE_PFC_CAPT = 4'h8;
  localparam logic [3:0] MODE_PFC_CMPA = 4'h9;
  localparam logic [3:0] MODE_PC_CAPT = 4'hA;
  localparam logic [3:0] MODE_PC_CMPA = 4'hB;
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  localparam logic [15:0] COUNT_FLOOR = 16'h0000;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  // Compare output codes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_NONINV = 2'h2;
  localparam logic [1:0] COM_INV = 2'h3;
  // Prescaler select codes and divide counts
  localparam logic [2:0] PRE_STOP = 3'h0;
  localparam logic [2:0] PRE_1 = 3'h1;
  localparam logic [2:0] PRE_8 = 3'h2;
  localparam logic [2:0] PRE_64 = 3'h3;
  localparam logic [2:0] PRE_256 = 3'h4;
  localparam logic [2:0] PRE_1024 = 3'h5;
  localparam logic [9:0] DIV_8_LAST = 10'h007;
  localparam logic [9:0] DIV_64_LAST = 10'h03F;
  localparam logic [9:0] DIV_256_LAST = 10'h0FF;
  localparam logic [9:0] DIV_1024_LAST = 10'h3FF;
  localparam logic [9:0] DIV_ONE = 10'h001;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  // Count direction
  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dir_t;
  // Per-channel output config
  typedef struct packed {
    logic [1:0] code;
    logic dir;
  } chan_cfg_t;
endpackage : pwm16_pkg

// [pwm16_dual_slope.sv]
// Dual-slope PWM timer with APB register access
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
// What this block does
// (R1) Modes 1,2,3,A,B run phase correct
// (R2) TOP from fixed value, capture or A
// (R3) Modes 8,9 run phase-frequency correct
// (R4) Counter holds TOP one tick, reverses
// (R5) Software keeps register TOP at least 3
// (R6) Code 2 clears up, sets down; 3 inverse
// (R7) Phase correct sets overflow at floor
// (R8) Phase correct: buffers load and flag at TOP
// (R9) Freq correct: buffers load, overflow at floor
// (R10) Freq correct: flag set when reaching TOP
// (R11) Channel flag set on compare match
// (R12) Fixed TOP masks high compare bits on write
// (R13) Software keeps TOP above compare values
// (R14) Compare zero low, equal TOP high
// (R15) Mode B code 1 toggles output A
// (R16) Mode 9 code 1 toggles output A
// (R17) Pin driven only when direction is output
// (R18) Prescaler divides by 1,8,64,256,1024
// (R19) Software prefers freq correct for TOP changes
// (R20) Code 0 leaves pin disconnected
// (R21) Code 1 disconnects elsewhere and channel B
// (R22) Updates on tick; reset zero, counting up
module pwm16_dual_slope (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_waveform_out_a,
  output logic o_waveform_out_b,
  output logic o_pin_drive_en_a_n,
  output logic o_pin_drive_en_b_n
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Fixed-resolution mask for compare writes
  function automatic logic [15:0] fixed_mask(input logic [3:0] mode);
    case (mode)
      pwm16_pkg::MODE_PC8: fixed_mask = pwm16_pkg::TOP_8;
      pwm16_pkg::MODE_PC9: fixed_mask = pwm16_pkg::TOP_9;
      pwm16_pkg::MODE_PC10: fixed_mask = pwm16_pkg::TOP_10;
      default: fixed_mask = 16'hFFFF;
    endcase
  endfunction : fixed_mask
  // Waveform next level for one channel
  function automatic logic wave_next(input logic cur, input logic [1:0] code,
      input logic match, input logic down, input logic toggle_ok);
    wave_next = cur;
    if (match) begin
      case (code)
        // (R6) Clear up, set down
        pwm16_pkg::COM_NONINV: wave_next = down;
        pwm16_pkg::COM_INV: wave_next = !down;
        // (R15) Toggle on match
        pwm16_pkg::COM_TOGGLE: wave_next = toggle_ok ? !cur : cur;
        default: wave_next = cur;
      endcase
    end
  endfunction : wave_next
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] ctrl_r, ctrl_nxt; // Mode, prescale, codes, directions
  logic [15:0] count_value_r, count_value_nxt;
  logic [15:0] compare_value_a_r, compare_value_a_nxt, compare_value_b_r, compare_value_b_nxt;
  logic [15:0] buf_a_r, buf_a_nxt, buf_b_r, buf_b_nxt; // Software-written buffers
  logic [15:0] capture_value_r, capture_value_nxt; // Not buffered
  logic [3:0] flags_r, flags_nxt; // Sticky event flags
  logic dir_r, dir_nxt; // Count direction
  logic wave_a_r, wave_a_nxt, wave_b_r, wave_b_nxt; // Waveform levels before the pins
  logic [9:0] pre_cnt_r, pre_cnt_nxt; // Prescaler counter
  logic tick_r, tick_nxt; // Timer clock enable
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt; // Bus answer strobes
  logic out_a_r, out_a_nxt, out_b_r, out_b_nxt;
  logic en_a_n_r, en_a_n_nxt, en_b_n_r, en_b_n_nxt;
  // Decoded fields
  logic [3:0] mode;
  logic [2:0] pre_sel;
  pwm16_pkg::chan_cfg_t cfg_a, cfg_b;
  logic pc_mode, pfc_mode, dual_mode, top_is_a, top_is_capt;
  logic [15:0] top_value;
  logic [9:0] div_last;
  logic at_top, at_floor, match_a, match_b, toggle_ok, wr_en, rd_en;
  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  always_comb begin
    mode = ctrl_r[pwm16_pkg::CTRL_MODE_LSB +: 4];
    pre_sel = ctrl_r[pwm16_pkg::CTRL_PRE_LSB +: 3];
    cfg_a.code = ctrl_r[pwm16_pkg::CTRL_COMA_LSB +: 2];
    cfg_a.dir = ctrl_r[pwm16_pkg::CTRL_DIRA_BIT];
    cfg_b.code = ctrl_r[pwm16_pkg::CTRL_COMB_LSB +: 2];
    cfg_b.dir = ctrl_r[pwm16_pkg::CTRL_DIRB_BIT];
    // (R1) Phase correct codes
    pc_mode = mode inside {pwm16_pkg::MODE_PC8, pwm16_pkg::MODE_PC9, pwm16_pkg::MODE_PC10,
                           pwm16_pkg::MODE_PC_CAPT, pwm16_pkg::MODE_PC_CMPA};
    // (R3) Phase and frequency correct codes
    pfc_mode = (mode == pwm16_pkg::MODE_PFC_CAPT) || (mode == pwm16_pkg::MODE_PFC_CMPA);
    dual_mode = pc_mode || pfc_mode;
    top_is_a = (mode == pwm16_pkg::MODE_PC_CMPA) || (mode == pwm16_pkg::MODE_PFC_CMPA);
    top_is_capt = (mode == pwm16_pkg::MODE_PC_CAPT) || (mode == pwm16_pkg::MODE_PFC_CAPT);
    // (R2) TOP source selection
    top_value = top_is_a ? compare_value_a_r :
                (top_is_capt ? capture_value_r : fixed_mask(mode));
    // (R16) Toggle allowed only in A-as-TOP modes
    toggle_ok = top_is_a;
    at_top = (count_value_r == top_value);
    at_floor = (count_value_r == pwm16_pkg::COUNT_FLOOR);
    match_a = (count_value_r == compare_value_a_r);
    match_b = (count_value_r == compare_value_b_r);
    wr_en = i_psel && i_penable && i_pwrite && !pready_r;
    rd_en = i_psel && i_penable && !i_pwrite && !pready_r;
  end
  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  // (R18) Select divide count
  always_comb begin
    case (pre_sel)
      pwm16_pkg::PRE_8: div_last = pwm16_pkg::DIV_8_LAST;
      pwm16_pkg::PRE_64: div_last = pwm16_pkg::DIV_64_LAST;
      pwm16_pkg::PRE_256: div_last = pwm16_pkg::DIV_256_LAST;
      pwm16_pkg::PRE_1024: div_last = pwm16_pkg::DIV_1024_LAST;
      default: div_last = '0;
    endcase
    pre_cnt_nxt = pre_cnt_r;
    tick_nxt = 1'b0;
    // Stopped prescaler gives no tick
    if (pre_sel == pwm16_pkg::PRE_STOP || pre_sel > pwm16_pkg::PRE_1024) begin
      pre_cnt_nxt = '0;
    end else if (pre_cnt_r >= div_last) begin
      pre_cnt_nxt = '0;
      tick_nxt = 1'b1;
    end else begin
      pre_cnt_nxt = pre_cnt_r + pwm16_pkg::DIV_ONE;
    end
  end
  // ----------------------------------------
  // Counter, compares, flags, waveforms, APB
  // ----------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    count_value_nxt = count_value_r;
    compare_value_a_nxt = compare_value_a_r;
    compare_value_b_nxt = compare_value_b_r;
    buf_a_nxt = buf_a_r;
    buf_b_nxt = buf_b_r;
    capture_value_nxt = capture_value_r;
    flags_nxt = flags_r;
    dir_nxt = dir_r;
    wave_a_nxt = wave_a_r;
    wave_b_nxt = wave_b_r;
    prdata_nxt = '0;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    // Software writes come first so hardware sets win
    if (wr_en) begin
      pready_nxt = 1'b1;
      case (i_paddr)
        pwm16_pkg::ADDR_CTRL: ctrl_nxt = i_pwdata[15:0];
        pwm16_pkg::ADDR_COUNT: count_value_nxt = i_pwdata[15:0];
        // (R12) Mask compare writes to fixed resolution
        pwm16_pkg::ADDR_CMP_A: buf_a_nxt = i_pwdata[15:0] & fixed_mask(mode);
        pwm16_pkg::ADDR_CMP_B: buf_b_nxt = i_pwdata[15:0] & fixed_mask(mode);
        pwm16_pkg::ADDR_CAPT: capture_value_nxt = i_pwdata[15:0];
        // Write one to clear
        pwm16_pkg::ADDR_FLAGS: flags_nxt = flags_r & ~i_pwdata[3:0];
        default: pslverr_nxt = 1'b1;
      endcase
    end else if (rd_en) begin
      pready_nxt = 1'b1;
      case (i_paddr)
        pwm16_pkg::ADDR_CTRL: prdata_nxt = {16'h0000, ctrl_r};
        pwm16_pkg::ADDR_COUNT: prdata_nxt = {16'h0000, count_value_r};
        pwm16_pkg::ADDR_CMP_A: prdata_nxt = {16'h0000, buf_a_r};
        pwm16_pkg::ADDR_CMP_B: prdata_nxt = {16'h0000, buf_b_r};
        pwm16_pkg::ADDR_CAPT: prdata_nxt = {16'h0000, capture_value_r};
        pwm16_pkg::ADDR_FLAGS: prdata_nxt = {28'h0000_000, flags_r};
        default: pslverr_nxt = 1'b1;
      endcase
    end
    // (R22) All dual-slope timer updates qualified by tick
    if (tick_r && dual_mode) begin
      // (R11) Channel flags on match
      if (match_a) flags_nxt[pwm16_pkg::FLG_CMPA] = 1'b1;
      if (match_b) flags_nxt[pwm16_pkg::FLG_CMPB] = 1'b1;
      // (R6) Waveform actions on match
      wave_a_nxt = wave_next(wave_a_r, cfg_a.code, match_a, dir_r, toggle_ok);
      wave_b_nxt = wave_next(wave_b_r, cfg_b.code, match_b, dir_r, 1'b0);
      // (R14) Extremes under code 2: zero stays low, TOP stays high; code 3 the opposite
      if (match_a && cfg_a.code[1] && (at_floor || at_top)) wave_a_nxt = cfg_a.code[0] ^ at_top;
      if (match_b && cfg_b.code[1] && (at_floor || at_top)) wave_b_nxt = cfg_b.code[0] ^ at_top;
      if (at_top) begin
        // (R4) Hold TOP one tick then count down
        dir_nxt = pwm16_pkg::DIR_DOWN;
        count_value_nxt = count_value_r - pwm16_pkg::COUNT_STEP;
        // (R8) Phase correct loads at TOP; (R10) flag at TOP
        if (top_is_a) flags_nxt[pwm16_pkg::FLG_CMPA] = 1'b1;
        if (top_is_capt) flags_nxt[pwm16_pkg::FLG_CAPT] = 1'b1;
        if (pc_mode) begin
          compare_value_a_nxt = buf_a_r;
          compare_value_b_nxt = buf_b_r;
        end
      end else if (at_floor) begin
        dir_nxt = pwm16_pkg::DIR_UP;
        count_value_nxt = count_value_r + pwm16_pkg::COUNT_STEP;
        // (R7) Overflow at floor
        flags_nxt[pwm16_pkg::FLG_OVF] = 1'b1;
        // (R9) Freq correct loads at floor
        if (pfc_mode) begin
          compare_value_a_nxt = buf_a_r;
          compare_value_b_nxt = buf_b_r;
        end
      end else if (dir_r == pwm16_pkg::DIR_DOWN) begin
        count_value_nxt = count_value_r - pwm16_pkg::COUNT_STEP;
      end else begin
        count_value_nxt = count_value_r + pwm16_pkg::COUNT_STEP;
      end
    end else if (!dual_mode) begin
      // Unsupported modes: buffers pass straight through
      compare_value_a_nxt = buf_a_r;
      compare_value_b_nxt = buf_b_r;
    end
  end
  // ----------------------------------------
  // Pin output stage
  // ----------------------------------------
  always_comb begin
    // (R20) Connected only for nonzero codes
    // (R21) Code 1 connects A only in toggle modes
    // (R17) Drive only when direction bit set
    en_a_n_nxt = !(cfg_a.dir && dual_mode && (cfg_a.code[1] ||
                  (cfg_a.code == pwm16_pkg::COM_TOGGLE && toggle_ok)));
    en_b_n_nxt = !(cfg_b.dir && dual_mode && cfg_b.code[1]);
    out_a_nxt = wave_a_nxt;
    out_b_nxt = wave_b_nxt;
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // (R22) Synchronous reset to zero except the active-low drive enables (high), counting up
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_r <= '0;
      count_value_r <= '0;
      compare_value_a_r <= '0;
      compare_value_b_r <= '0;
      buf_a_r <= '0;
      buf_b_r <= '0;
      capture_value_r <= '0;
      flags_r <= '0;
      dir_r <= pwm16_pkg::DIR_UP;
      wave_a_r <= 1'b0;
      wave_b_r <= 1'b0;
      pre_cnt_r <= '0;
      tick_r <= 1'b0;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      out_a_r <= 1'b0;
      out_b_r <= 1'b0;
      en_a_n_r <= 1'b1;
      en_b_n_r <= 1'b1;
    end else begin
      ctrl_r <= ctrl_nxt;
      count_value_r <= count_value_nxt;
      compare_value_a_r <= compare_value_a_nxt;
      compare_value_b_r <= compare_value_b_nxt;
      buf_a_r <= buf_a_nxt;
      buf_b_r <= buf_b_nxt;
      capture_value_r <= capture_value_nxt;
      flags_r <= flags_nxt;
      dir_r <= dir_nxt;
      wave_a_r <= wave_a_nxt;
      wave_b_r <= wave_b_nxt;
      pre_cnt_r <= pre_cnt_nxt;
      tick_r <= tick_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      out_a_r <= out_a_nxt;
      out_b_r <= out_b_nxt;
      en_a_n_r <= en_a_n_nxt;
      en_b_n_r <= en_b_n_nxt;
    end
  end
  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_waveform_out_a = out_a_r;
  assign o_waveform_out_b = out_b_r;
  assign o_pin_drive_en_a_n = en_a_n_r;
  assign o_pin_drive_en_b_n = en_b_n_r;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_top_reverse: assert property (@(posedge i_clk) disable iff (i_reset) // (R4)
    (tick_r && dual_mode && at_top && !wr_en) |=> (dir_r == pwm16_pkg::DIR_DOWN))
    else $error("counter did not reverse at TOP");
  a_floor_overflow: assert property (@(posedge i_clk) disable iff (i_reset) // (R7)
    (tick_r && dual_mode && at_floor && !at_top) |=> flags_r[pwm16_pkg::FLG_OVF])
    else $error("overflow flag missing at floor");
  a_match_flag: assert property (@(posedge i_clk) disable iff (i_reset) // (R11)
    (tick_r && dual_mode && match_b) |=> flags_r[pwm16_pkg::FLG_CMPB])
    else $error("compare B flag missing");
  a_pc_load_top: assert property (@(posedge i_clk) disable iff (i_reset) // (R8)
    (tick_r && pc_mode && at_top) |=> (compare_value_b_r == $past(buf_b_r)))
    else $error("compare not loaded at TOP");
  a_pfc_load_floor: assert property (@(posedge i_clk) disable iff (i_reset) // (R9)
    (tick_r && pfc_mode && at_floor && !at_top) |=> (compare_value_b_r == $past(buf_b_r)))
    else $error("compare not loaded at floor");
  a_drive_gate: assert property (@(posedge i_clk) disable iff (i_reset) // (R17)
    !cfg_b.dir |=> o_pin_drive_en_b_n)
    else $error("pin B driven without direction");
  a_chan_b_code1: assert property (@(posedge i_clk) disable iff (i_reset) // (R21)
    (cfg_b.code == pwm16_pkg::COM_TOGGLE) |=> o_pin_drive_en_b_n)
    else $error("channel B connected under code 1");
  a_tick_stop: assert property (@(posedge i_clk) disable iff (i_reset) // (R18)
    (pre_sel == pwm16_pkg::PRE_STOP) |=> !tick_r)
    else $error("tick while prescaler stopped");
  a_up_count: assert property (@(posedge i_clk) disable iff (i_reset) // (R1)
    (tick_r && dual_mode && !at_top && !at_floor && dir_r == pwm16_pkg::DIR_UP && !wr_en)
    |=> (count_value_r == $past(count_value_r) + pwm16_pkg::COUNT_STEP))
    else $error("counter did not step up");
  c_top_hit: cover property (@(posedge i_clk) tick_r && pc_mode && at_top);
  c_pfc_floor: cover property (@(posedge i_clk) tick_r && pfc_mode && at_floor);
  c_toggle_a: cover property (@(posedge i_clk) tick_r && toggle_ok && match_a);
endmodule : pwm16_dual_slope

// [pwm_pin_load.sv]
// Load model that resolves one compare pin and times its high and low runs
`timescale 1ns/1ps
// ----------------------------------------
// Pin load with pull-up
// ----------------------------------------
module pwm_pin_load (
  input wire logic i_clk,
  input wire logic i_wave,
  input wire logic i_drive_en_n,
  output logic o_pin,
  output logic [15:0] o_last_high,
  output logic [15:0] o_last_low,
  output logic [15:0] o_edges
);
  logic [15:0] run_r = 16'h0000; // Cycles spent at the current level
  logic [15:0] high_r = 16'h0000; // Last finished high run
  logic [15:0] low_r = 16'h0000; // Last finished low run
  logic [15:0] edges_r = 16'h0000; // Level changes so far
  logic prev_r = 1'b1; // Level seen at the previous edge
  // Pin shows the waveform only while the driver is enabled
  // Undriven pin floats to the pull-up, so a stale level never shows
  assign o_pin = i_drive_en_n ? 1'b1 : i_wave;
  assign o_last_high = high_r;
  assign o_last_low = low_r;
  assign o_edges = edges_r;
  // Time each level; a change stores the finished run
  always @(posedge i_clk) begin
    if (o_pin !== prev_r) begin
      if (prev_r) high_r <= run_r;
      else low_r <= run_r;
      edges_r <= edges_r + 16'h0001;
      run_r <= 16'h0001;
    end else begin
      run_r <= run_r + 16'h0001;
    end
    prev_r <= o_pin;
  end
endmodule : pwm_pin_load

// [tb_pwm16_dual_slope.sv]
// Self-checking testbench for the dual-slope PWM timer
`timescale 1ns/1ps
module tb_pwm16_dual_slope;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, wa, wb, en_a_n, en_b_n, pin_a, pin_b;
  logic [15:0] ha, la, hb, lb, ea, eb, e0;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  // Clock at 200 MHz
  always #2.5 i_clk = ~i_clk;
  pwm16_dual_slope uut (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_waveform_out_a(wa), .o_waveform_out_b(wb),
    .o_pin_drive_en_a_n(en_a_n), .o_pin_drive_en_b_n(en_b_n));
  pwm_pin_load load_a (.i_clk(i_clk), .i_wave(wa), .i_drive_en_n(en_a_n), .o_pin(pin_a),
    .o_last_high(ha), .o_last_low(la), .o_edges(ea));
  pwm_pin_load load_b (.i_clk(i_clk), .i_wave(wb), .i_drive_en_n(en_b_n), .o_pin(pin_b),
    .o_last_high(hb), .o_last_low(lb), .o_edges(eb));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  // Hang guard: the tests need about 4300 cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    // Ends when pready is sampled high; only the hang guard ends it if pready never rises
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk("wr slverr", 32'h0000_0000, {31'h0000_0000, er});
  endtask : wr
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk("rd slverr", 32'h0000_0000, {31'h0000_0000, er});
    chk(nm, e, rd);
  endtask : rchk
  function automatic logic [31:0] ctrl(logic [3:0] m, logic [2:0] p, logic [1:0] ca,
    logic [1:0] cb, logic da, logic db);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[pwm16_pkg::CTRL_MODE_LSB +: 4] = m;
    v[pwm16_pkg::CTRL_PRE_LSB +: 3] = p;
    v[pwm16_pkg::CTRL_COMA_LSB +: 2] = ca;
    v[pwm16_pkg::CTRL_COMB_LSB +: 2] = cb;
    v[pwm16_pkg::CTRL_DIRA_BIT] = da;
    v[pwm16_pkg::CTRL_DIRB_BIT] = db;
    return v;
  endfunction : ctrl
  // Load compares with the counter parked, TOP 20 in capture, then start
  task run(input logic [3:0] m, input logic [2:0] p, input logic [15:0] a, input logic [15:0] b,
    input logic [1:0] ca, input logic [1:0] cb, input int w);
    wr(pwm16_pkg::ADDR_CTRL, 32'h0000_0000);
    wr(pwm16_pkg::ADDR_CMP_A, {16'h0000, a});
    wr(pwm16_pkg::ADDR_CMP_B, {16'h0000, b});
    wr(pwm16_pkg::ADDR_CAPT, 32'h0000_0014);
    wr(pwm16_pkg::ADDR_COUNT, 32'h0000_0000);
    wr(pwm16_pkg::ADDR_FLAGS, 32'h0000_000F);
    wr(pwm16_pkg::ADDR_CTRL, ctrl(m, p, ca, cb, 1'b1, 1'b1));
    repeat (w) @(posedge i_clk);
  endtask : run
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  logic [3:0] fm[3] = '{pwm16_pkg::MODE_PC8, pwm16_pkg::MODE_PC9, pwm16_pkg::MODE_PC10};
  logic [15:0] ft[3] = '{pwm16_pkg::TOP_8, pwm16_pkg::TOP_9, pwm16_pkg::TOP_10};
  logic [3:0] pm[2] = '{pwm16_pkg::MODE_PC_CAPT, pwm16_pkg::MODE_PFC_CAPT};
  logic [3:0] tm[2] = '{pwm16_pkg::MODE_PC_CMPA, pwm16_pkg::MODE_PFC_CMPA};
  logic [2:0] tp[2] = '{pwm16_pkg::PRE_1, pwm16_pkg::PRE_8};
  int tn[2] = '{1, 8};
  initial begin
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    rchk("ctrl", pwm16_pkg::ADDR_CTRL, 32'h0000_0000);
    rchk("count", pwm16_pkg::ADDR_COUNT, 32'h0000_0000);
    rchk("flags", pwm16_pkg::ADDR_FLAGS, 32'h0000_0000);
    chk("en_a_n", 32'h0000_0001, {31'h0000_0000, en_a_n});
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0000_0000, er});
    chk("unmapped data", 32'h0000_0000, rd);
    // Fixed TOP modes mask the high compare bits on write
    for (int i = 0; i < 3; i++) begin
      wr(pwm16_pkg::ADDR_CTRL, ctrl(fm[i], pwm16_pkg::PRE_STOP, 2'h0, 2'h0, 1'b0, 1'b0));
      wr(pwm16_pkg::ADDR_CMP_A, 32'h0000_FFFF);
      rchk("cmp_a mask", pwm16_pkg::ADDR_CMP_A, {16'h0000, ft[i]});
    end
    // PWM A non-inverted at 5, B inverted at 12, TOP 20, no prescale
    // TOP held still while counting
    for (int i = 0; i < 2; i++) begin
      run(pm[i], pwm16_pkg::PRE_1, 16'h0005, 16'h000C, pwm16_pkg::COM_NONINV,
        pwm16_pkg::COM_INV, 200);
      chk("a high", 32'h0000_000A, {16'h0000, ha});
      chk("a low", 32'h0000_001E, {16'h0000, la});
      chk("b high", 32'h0000_0010, {16'h0000, hb});
      chk("b low", 32'h0000_0018, {16'h0000, lb});
      chk("en_a_n", 32'h0000_0000, {31'h0000_0000, en_a_n});
      rchk("flags", pwm16_pkg::ADDR_FLAGS, 32'h0000_000F);
      wr(pwm16_pkg::ADDR_CTRL, 32'h0000_0000);
      wr(pwm16_pkg::ADDR_FLAGS, 32'h0000_000F);
      rchk("flags clr", pwm16_pkg::ADDR_FLAGS, 32'h0000_0000);
    end
    // Toggle on A with compare A as TOP; B stays disconnected
    for (int i = 0; i < 2; i++) begin
      run(tm[i], tp[i], 16'h0014, 16'h0005, pwm16_pkg::COM_TOGGLE, pwm16_pkg::COM_TOGGLE,
        300 + 150 * tn[i]);
      chk("tog high", 40 * tn[i], {16'h0000, ha});
      chk("tog low", 40 * tn[i], {16'h0000, la});
      chk("en_b_n", 32'h0000_0001, {31'h0000_0000, en_b_n});
    end
    // Extreme compares: A at floor, B at TOP, both polarities
    for (int j = 0; j < 2; j++) begin
      run(pwm16_pkg::MODE_PC_CAPT, pwm16_pkg::PRE_1, 16'h0000, 16'h0014,
        j ? pwm16_pkg::COM_INV : pwm16_pkg::COM_NONINV,
        j ? pwm16_pkg::COM_INV : pwm16_pkg::COM_NONINV, 100);
      e0 = ea + eb;
      repeat (100) @(posedge i_clk);
      chk("steady", {16'h0000, e0}, {16'h0000, ea + eb});
      chk("pin a", j, {31'h0000_0000, pin_a});
      chk("pin b", 1 - j, {31'h0000_0000, pin_b});
    end
    // Output driver only for a connected code with direction set
    wr(pwm16_pkg::ADDR_CTRL, ctrl(pm[0], pwm16_pkg::PRE_1, pwm16_pkg::COM_OFF, 2'h0, 1'b1, 1'b0));
    repeat (3) @(posedge i_clk);
    chk("en off", 32'h0000_0001, {31'h0000_0000, en_a_n});
    wr(pwm16_pkg::ADDR_CTRL, ctrl(pm[0], pwm16_pkg::PRE_1, pwm16_pkg::COM_NONINV, 2'h0, 1'b0, 1'b0));
    repeat (3) @(posedge i_clk);
    chk("en dir", 32'h0000_0001, {31'h0000_0000, en_a_n});
    wr(pwm16_pkg::ADDR_CTRL, ctrl(pm[0], pwm16_pkg::PRE_1, pwm16_pkg::COM_TOGGLE, 2'h0, 1'b1, 1'b0));
    repeat (3) @(posedge i_clk);
    chk("en tog", 32'h0000_0001, {31'h0000_0000, en_a_n});
    // Fixed TOP 0x00FF: high run is twice the compare, period twice TOP
    run(pwm16_pkg::MODE_PC8, pwm16_pkg::PRE_1, 16'h0080, 16'h0000, pwm16_pkg::COM_NONINV,
      pwm16_pkg::COM_OFF, 1200);
    chk("fix high", 32'h0000_0100, {16'h0000, ha});
    chk("fix low", 32'h0000_00FE, {16'h0000, la});
    end_sim();
  end
endmodule : tb_pwm16_dual_slope
